// [verification/txcbp_assertions.sv]
// port-level assertions for the tx command buffer parser
`timescale 1ns/1ps
module txcbp_assertions
  import txcbp_pkg::*;
(
  input wire logic                  clk,
  input wire logic                  rstn,
  input wire logic                  wr_valid,
  input wire logic                  err_clr,
  input wire txcbp_pkg::txcbp_dw_s  mac_dw_ff,
  input wire logic                  mac_valid_ff,
  input wire txcbp_pkg::txcbp_ctl_s mac_ctl_ff,
  input wire logic                  status_valid_ff,
  input wire logic [15:0]           status_tag_ff,
  input wire logic                  transmitter_error_flag_ff
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  // set by a forwarded end of packet, cleared by the status pulse; padding
  // and host gaps may sit between the two, so no fixed delay is assumed
  logic eop_open_ff;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      eop_open_ff <= 1'b0;
    end else if (status_valid_ff) begin
      eop_open_ff <= 1'b0;
    end else if (mac_valid_ff && mac_dw_ff.eop) begin
      eop_open_ff <= 1'b1;
    end
  end
  //////////////////////////////////////////////////////////////////////////
  // forwarded dwords and packet close
  property p_fwd_cause; mac_valid_ff |-> $past(wr_valid); endproperty
  a_fwd_cause: assert property (p_fwd_cause)
    else $error("dword from nothing");
  property p_no_empty; mac_valid_ff |-> mac_dw_ff.be != 4'h0; endproperty
  a_no_empty: assert property (p_no_empty)
    else $error("empty dword sent");
  property p_eop_close; eop_open_ff |-> !mac_valid_ff; endproperty
  a_eop_close: assert property (p_eop_close)
    else $error("dword after eop before status");
  property p_stat_pulse; status_valid_ff |=> !status_valid_ff; endproperty
  a_stat_pulse: assert property (p_stat_pulse)
    else $error("status long");
  property p_tag_hold; $changed(status_tag_ff) |-> status_valid_ff;
  endproperty
  a_tag_hold: assert property (p_tag_hold)
    else $error("tag moved");
  // controls only move on a taken command word; no pad implies crc
  property p_ctl_cause; $changed(mac_ctl_ff) |-> $past(wr_valid); endproperty
  a_ctl_cause: assert property (p_ctl_cause)
    else $error("ctl moved");
  // the all-zero reset value is not a loaded control, so only loads count
  property p_crc_kept;
    $changed(mac_ctl_ff) && !mac_ctl_ff.pad_enable |-> mac_ctl_ff.crc_append;
  endproperty
  a_crc_kept: assert property (p_crc_kept)
    else $error("crc dropped");
  // error flag is sticky until cleared and only rises after host traffic
  property p_err_sticky;
    transmitter_error_flag_ff && !err_clr |=> transmitter_error_flag_ff;
  endproperty
  a_err_sticky: assert property (p_err_sticky)
    else $error("flag lost");
  property p_err_cause; $rose(transmitter_error_flag_ff) |-> $past(wr_valid);
  endproperty
  a_err_cause: assert property (p_err_cause)
    else $error("flag uncaused");
endmodule
bind txcbp_top txcbp_assertions txcbp_assertions_i (.clk(clk), .rstn(rstn),
  .wr_valid(wr_valid), .err_clr(err_clr), .mac_dw_ff(mac_dw_ff),
  .mac_valid_ff(mac_valid_ff), .mac_ctl_ff(mac_ctl_ff),
  .status_valid_ff(status_valid_ff), .status_tag_ff(status_tag_ff),
  .transmitter_error_flag_ff(transmitter_error_flag_ff));

// [verification/txcbp_host_model.sv]
// host cpu model writing command words and padded buffer data
`timescale 1ns/1ps
module txcbp_host_model (
  input  wire logic        clk,
  output logic             wr_valid,
  output logic [31:0]      wr_data
);
  initial begin
    wr_valid = 1'b0;
    wr_data  = 32'h0;
  end
  // one word per edge, no back-pressure exists
  task automatic put(input logic [31:0] w);
    wr_valid <= 1'b1;
    wr_data  <= w;
    @(posedge clk);
  endtask
  // whole buffer: a, b, then data padded to the alignment; reserved zero
  task automatic send(input logic f, l, input logic [4:0] off,
                      input logic [10:0] sz, input logic [1:0] al,
                      input logic [31:0] b);
    int m;
    int n;
    m = (al == 2'h2) ? 31 : (al == 2'h1) ? 15 : 3;
    n = ((int'(off) + int'(sz) + m) & ~m) / 4;
    put({6'h0, al, 3'h0, off, 2'h0, f, l, 1'h0, sz});
    put(b);
    for (int i = 0; i < n; i++) put(32'hd000_0000 + i);
    // released bus shows the inverse so stale data never looks valid
    wr_valid <= 1'b0;
    wr_data  <= ~wr_data;
  endtask
endmodule

// [verification/txcbp_tb_top.sv]
// self-checking bench for the tx command buffer parser
`timescale 1ns/1ps
module txcbp_tb_top;
  import txcbp_pkg::*;
  logic        clk = 1'b0, rstn = 1'b0, err_clr = 1'b0, wr_valid;
  logic [31:0] wr_data;
  txcbp_dw_s   mac_dw_ff;
  txcbp_ctl_s  mac_ctl_ff;
  logic        mac_valid_ff, status_valid_ff, status_len_err_ff;
  logic        transmitter_error_flag_ff;
  logic [15:0] status_tag_ff;
  int          num_errors = 0, cmp_count = 0, cyc = 0, sn = 0;
  txcbp_dw_s   dq[$];
  txcbp_top txcbp_top_i (.clk(clk), .rstn(rstn), .wr_valid(wr_valid),
    .wr_data(wr_data), .err_clr(err_clr), .mac_dw_ff(mac_dw_ff),
    .mac_valid_ff(mac_valid_ff), .mac_ctl_ff(mac_ctl_ff),
    .status_valid_ff(status_valid_ff), .status_tag_ff(status_tag_ff),
    .status_len_err_ff(status_len_err_ff),
    .transmitter_error_flag_ff(transmitter_error_flag_ff));
  txcbp_host_model txcbp_host_model_i (.clk(clk), .wr_valid(wr_valid),
    .wr_data(wr_data));
  always #20 clk = ~clk;
  //////////////////////////////////////////////////////////////////////////
  // collect forwarded dwords and closes; cap the run against hangs
  always @(posedge clk) begin
    if (mac_valid_ff === 1'b1) dq.push_back(mac_dw_ff);
    if (status_valid_ff === 1'b1) sn++;
    cyc++;
    if (cyc == 3000) begin
      num_errors++;
      print_verdict();
    end
  end
  task automatic chk(input string nm, input logic [31:0] s, e);
    cmp_count++;
    if (s !== e) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask
  function automatic logic [31:0] mkb(logic [15:0] t, logic c, p,
                                      logic [10:0] len);
    return {t, 2'h0, c, p, 1'h0, len};
  endfunction
  function automatic logic [5:0] fl(txcbp_dw_s d);
    return {d.be, d.sop, d.eop};
  endfunction
  task automatic settle();
    repeat (3) @(posedge clk);
  endtask
  //////////////////////////////////////////////////////////////////////////
  // single buffer, byte-ragged end
  task automatic t_single();
    dq.delete();
    sn = 0;
    txcbp_host_model_i.send(1, 1, 0, 5, ALIGN_4, mkb(16'h1234, 0, 0, 5));
    settle();
    chk("count", 32'(dq.size()), 2);
    chk("d0", dq[0].data, 32'hd000_0000);
    chk("f0", 32'(fl(dq[0])), 32'h3e);
    chk("f1", 32'(fl(dq[1])), 32'h05);
    chk("stat", {15'h0, status_len_err_ff, status_tag_ff}, 32'h1234);
    chk("ctl", 32'(mac_ctl_ff), 32'h4_8d3);
  endtask
  // two segments, offset 7, 16-byte padding, crc and pad disable bits set, crc still appended
  task automatic t_frag();
    dq.delete();
    sn = 0;
    txcbp_host_model_i.send(1, 0, 7, 79, ALIGN_16, mkb(16'h00a1, 1, 1, 94));
    @(posedge clk);
    txcbp_host_model_i.send(0, 1, 0, 15, ALIGN_16, 32'h0);
    settle();
    chk("count", 32'(dq.size()), 25);
    chk("d0", dq[0].data, 32'hd000_0001);
    chk("f0", 32'(fl(dq[0])), 32'h22);
    chk("f20", 32'(fl(dq[20])), 32'h0c);
    chk("f21", 32'(fl(dq[21])), 32'h3c);
    chk("f24", 32'(fl(dq[24])), 32'h1d);
    chk("ctl", 32'(mac_ctl_ff), 32'h2_86);
    chk("lenerr", {sn[30:0], status_len_err_ff}, {31'd1, 1'b0});
  endtask
  // length mismatch, clear, then an orphan last buffer
  task automatic t_err();
    dq.delete();
    txcbp_host_model_i.send(1, 1, 0, 5, ALIGN_32, mkb(16'h0bad, 1, 0, 6));
    settle();
    chk("count", 32'(dq.size()), 2);
    chk("lenerr", 32'(status_len_err_ff), 1);
    chk("flag", 32'(transmitter_error_flag_ff), 1);
    chk("ctl", 32'(mac_ctl_ff), 32'h2_eb5);
    err_clr <= 1'b1;
    @(posedge clk);
    err_clr <= 1'b0;
    settle();
    chk("clr", 32'(transmitter_error_flag_ff), 0);
    dq.delete();
    txcbp_host_model_i.send(0, 1, 0, 4, ALIGN_4, 32'h0);
    settle();
    chk("orphan", {31'(dq.size()), transmitter_error_flag_ff},
        32'h1);
  endtask
  // first segment inside an open packet, then a last buffer of zero size
  task automatic t_restart();
    dq.delete();
    sn = 0;
    err_clr <= 1'b1;
    @(posedge clk);
    err_clr <= 1'b0;
    txcbp_host_model_i.send(1, 0, 0, 4, ALIGN_4, mkb(16'h0001, 0, 0, 8));
    @(posedge clk);
    txcbp_host_model_i.send(1, 0, 0, 4, ALIGN_4, mkb(16'h0002, 0, 0, 4));
    @(posedge clk);
    txcbp_host_model_i.send(0, 1, 0, 0, ALIGN_4, 32'h0);
    settle();
    chk("rcount", 32'(dq.size()), 2);
    chk("rflag", 32'(transmitter_error_flag_ff), 1);
    chk("rsn", sn, 1);
    chk("rstat", {15'h0, status_len_err_ff, status_tag_ff},
        32'h0002);
  endtask
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    t_single();
    t_frag();
    t_err();
    t_restart();
    print_verdict();
  end
endmodule

// [verilog/txcbp_geom.sv]
// buffer geometry calculator: skip, data and padding dwords from command a
`timescale 1ns/1ps
module txcbp_geom (
  input  wire logic [31:0]         cmd_a,
  output txcbp_pkg::txcbp_geo_s    geo
);
  import txcbp_pkg::*;

  logic [10:0] size;
  logic [4:0]  off;
  logic [11:0] span;
  logic [11:0] amask;
  logic [11:0] rounded;
  logic [11:0] span_up;
  logic [11:0] span_m1;

  // byte span of offset plus valid data, then rounded to the alignment
  always_comb begin
    size    = cmd_a[A_SIZE_MSB:A_SIZE_LSB];
    off     = cmd_a[A_OFF_MSB:A_OFF_LSB];
    span    = {1'b0, size} + {7'h00, off};
    unique case (cmd_a[A_ALIGN_MSB:A_ALIGN_LSB])
      ALIGN_16: amask = MASK_16;
      ALIGN_32: amask = MASK_32;
      default:  amask = MASK_4;   // reserved code treated as 4-byte
    endcase
    rounded = (span + amask) & ~amask;
    span_up = span + MASK_4;
    span_m1 = span - 12'h001;
  end

  // data ends inside the dword holding the last valid byte
  always_comb begin
    geo.skip_dw  = off[4:2];
    geo.total_dw = rounded[11:2];
    geo.data_end = (size == 11'h000) ? {7'h00, off[4:2]}
                                     : span_up[11:2];
    geo.be_first = 4'hf << off[1:0];
    geo.be_last  = 4'hf >> (2'h3 - span_m1[1:0]);
  end

endmodule

// [verilog/txcbp_pkg.sv]
// shared constants and carrier types for the tx command buffer parser
package txcbp_pkg;

  // command word a field positions
  localparam int A_FIRST_BIT = 13;
  localparam int A_LAST_BIT  = 12;
  localparam int A_SIZE_MSB  = 10;
  localparam int A_SIZE_LSB  = 0;
  localparam int A_ALIGN_MSB = 25;
  localparam int A_ALIGN_LSB = 24;
  localparam int A_OFF_MSB   = 20;
  localparam int A_OFF_LSB   = 16;

  // command word b field positions
  localparam int B_TAG_MSB     = 31;
  localparam int B_TAG_LSB     = 16;
  localparam int B_CRC_DIS_BIT = 13;
  localparam int B_PAD_DIS_BIT = 12;
  localparam int B_LEN_MSB     = 10;
  localparam int B_LEN_LSB     = 0;

  // end alignment encodings; the fourth code is reserved
  localparam logic [1:0] ALIGN_4  = 2'h0;
  localparam logic [1:0] ALIGN_16 = 2'h1;
  localparam logic [1:0] ALIGN_32 = 2'h2;

  // round-up masks in bytes for each alignment
  localparam logic [11:0] MASK_4  = 12'h003;
  localparam logic [11:0] MASK_16 = 12'h00f;
  localparam logic [11:0] MASK_32 = 12'h01f;

  // reset values
  localparam logic [31:0] DATA_RST = 32'h0000_0000;
  localparam logic [15:0] TAG_RST  = 16'h0000;

  // one data dword towards the mac path; lane 0 is d[7:0]
  typedef struct packed {
    logic [31:0] data;
    logic [3:0]  be;
    logic        sop;
    logic        eop;
  } txcbp_dw_s;

  // per packet controls handed to the mac path
  typedef struct packed {
    logic [15:0] tag;
    logic        crc_append;
    logic        pad_enable;
  } txcbp_ctl_s;

  // buffer geometry worked out from command word a
  typedef struct packed {
    logic [2:0] skip_dw;
    logic [9:0] data_end;
    logic [9:0] total_dw;
    logic [3:0] be_first;
    logic [3:0] be_last;
  } txcbp_geo_s;

  typedef enum logic [1:0] {
    ST_CMD_A,
    ST_CMD_B,
    ST_BODY
  } txcbp_state_e;

endpackage

// [verilog/txcbp_top.sv]
// tx command buffer parser: command a, command b, payload dwords to mac path
`timescale 1ns/1ps
module txcbp_top (
  input  wire logic                clk,
  input  wire logic                rstn,
  input  wire logic                wr_valid,
  input  wire logic [31:0]         wr_data,
  input  wire logic                err_clr,
  output txcbp_pkg::txcbp_dw_s     mac_dw_ff,
  output logic                     mac_valid_ff,
  output txcbp_pkg::txcbp_ctl_s    mac_ctl_ff,
  output logic                     status_valid_ff,
  output logic [15:0]              status_tag_ff,
  output logic                     status_len_err_ff,
  output logic                     transmitter_error_flag_ff
);
  import txcbp_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // parser state

  txcbp_state_e state_ff;
  txcbp_geo_s   geo;
  txcbp_geo_s   geo_ff;
  logic [9:0]   idx_ff;
  logic         first_segment_flag_ff;
  logic         last_seg_ff;
  logic         drop_ff;
  logic         in_pkt_ff;
  logic [11:0]  sum_ff;
  logic [10:0]  len_ff;
  logic [15:0]  tag_ff;

  logic         take_a;
  logic         take_b;
  logic         take_d;
  logic         first_a;
  logic         orphan_a;
  logic         restart_a;
  logic         buf_done;
  logic         pkt_done;
  logic         len_bad;
  logic         in_data;
  logic [9:0]   last_idx;
  logic [10:0]  size_a;

  txcbp_geom txcbp_geom_i (
    .cmd_a (wr_data),
    .geo   (geo)
  );

  ////////////////////////////////////////////////////////////////////////////
  // decode of the incoming word against the current position

  always_comb begin
    take_a    = wr_valid && (state_ff == ST_CMD_A);
    take_b    = wr_valid && (state_ff == ST_CMD_B);
    take_d    = wr_valid && (state_ff == ST_BODY);
    first_a   = wr_data[A_FIRST_BIT];
    size_a    = wr_data[A_SIZE_MSB:A_SIZE_LSB];
    // a middle or last buffer with no open packet has nothing to join
    orphan_a  = take_a && !first_a && !in_pkt_ff;
    // a new first segment cuts short a packet that never saw its last
    restart_a = take_a && first_a && in_pkt_ff;
    last_idx  = geo_ff.total_dw - 10'h001;
    in_data   = (idx_ff >= {7'h00, geo_ff.skip_dw}) &&
                (idx_ff < geo_ff.data_end);
    // a buffer ends on its final padded dword, or at b if it has none
    buf_done  = (take_d && (idx_ff == last_idx)) ||
                (take_b && (geo_ff.total_dw == 10'h000));
    pkt_done  = buf_done && last_seg_ff && !drop_ff;
    len_bad   = sum_ff != {1'b0, len_ff};
  end

  ////////////////////////////////////////////////////////////////////////////
  // word sequence: a, b, then every data and padding dword of the buffer

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_ff <= ST_CMD_A;
    end else begin
      unique case (state_ff)
        ST_CMD_A: if (take_a) state_ff <= ST_CMD_B;
        ST_CMD_B: if (take_b) begin
          state_ff <= buf_done ? ST_CMD_A : ST_BODY;
        end
        ST_BODY:  if (buf_done) state_ff <= ST_CMD_A;
      endcase
    end
  end

  // dword index within the data section, counted from the third word
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      idx_ff <= 10'h000;
    end else if (take_b) begin
      idx_ff <= 10'h000;
    end else if (take_d) begin
      idx_ff <= idx_ff + 10'h001;
    end
  end

  // buffer description captured from command a
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      geo_ff                <= '0;
      first_segment_flag_ff <= 1'b0;
      last_seg_ff           <= 1'b0;
      drop_ff               <= 1'b0;
    end else if (take_a) begin
      geo_ff                <= geo;
      first_segment_flag_ff <= first_a;
      last_seg_ff           <= wr_data[A_LAST_BIT];
      drop_ff               <= orphan_a;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // packet tracking: open on first segment, close after the last buffer

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      in_pkt_ff <= 1'b0;
    end else if (take_a && first_a) begin
      in_pkt_ff <= 1'b1;
    end else if (pkt_done) begin
      in_pkt_ff <= 1'b0;
    end
  end

  // running byte count, restarted by each first segment
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sum_ff <= 12'h000;
    end else if (take_a && first_a) begin
      sum_ff <= {1'b0, size_a};
    end else if (take_a && in_pkt_ff) begin
      sum_ff <= sum_ff + {1'b0, size_a};
    end
  end

  // packet fields of b are kept only for a first segment buffer
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      len_ff     <= 11'h000;
      tag_ff     <= TAG_RST;
      mac_ctl_ff <= '0;
    end else if (take_b && first_segment_flag_ff) begin
      len_ff                <= wr_data[B_LEN_MSB:B_LEN_LSB];
      tag_ff                <= wr_data[B_TAG_MSB:B_TAG_LSB];
      mac_ctl_ff.tag        <= wr_data[B_TAG_MSB:B_TAG_LSB];
      // padding off forces the check sequence on, whatever the crc bit
      mac_ctl_ff.crc_append <= !wr_data[B_CRC_DIS_BIT] ||
                               wr_data[B_PAD_DIS_BIT];
      mac_ctl_ff.pad_enable <= !wr_data[B_PAD_DIS_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // mac path dwords: only dwords holding valid bytes, with byte lanes

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      mac_valid_ff <= 1'b0;
      mac_dw_ff    <= '{data: DATA_RST, be: 4'h0, sop: 1'b0, eop: 1'b0};
    end else begin
      // skipped dwords, padding and orphan buffers never leave here
      mac_valid_ff   <= take_d && in_data && !drop_ff;
      mac_dw_ff.data <= wr_data;
      mac_dw_ff.be   <=
        ((idx_ff == {7'h00, geo_ff.skip_dw}) ? geo_ff.be_first : 4'hf) &
        ((idx_ff == geo_ff.data_end - 10'h001) ? geo_ff.be_last : 4'hf);
      mac_dw_ff.sop  <= first_segment_flag_ff &&
                        (idx_ff == {7'h00, geo_ff.skip_dw});
      mac_dw_ff.eop  <= last_seg_ff &&
                        (idx_ff == geo_ff.data_end - 10'h001);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // status word and error flag

  // one status pulse per closed packet, tag and length verdict with it
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      status_valid_ff   <= 1'b0;
      status_tag_ff     <= TAG_RST;
      status_len_err_ff <= 1'b0;
    end else begin
      status_valid_ff <= pkt_done;
      if (pkt_done) begin
        status_tag_ff     <= tag_ff;
        status_len_err_ff <= len_bad;
      end
    end
  end

  // sticky; a new error in the clearing cycle wins over the clear
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      transmitter_error_flag_ff <= 1'b0;
    end else if ((pkt_done && len_bad) || orphan_a || restart_a) begin
      transmitter_error_flag_ff <= 1'b1;
    end else if (err_clr) begin
      transmitter_error_flag_ff <= 1'b0;
    end
  end

endmodule
